// File: inc/acpc_params.svh
// Constants for the conversion and power control block
`ifndef ACPC_PARAMS_SVH
`define ACPC_PARAMS_SVH
`define ACPC_CMD_RESET 8'h58
`define ACPC_CMD_START_POS 1
`define ACPC_CMD_STOP_POS 0
`define ACPC_CFG_FIRST 8'h04
`define ACPC_CFG_LAST 8'h0E
`define ACPC_WAKE_CYC 24
`define ACPC_RESULT_READY_N_HOLD 2'h3
`define ACPC_ONES_P1 11'h3FF
`define ACPC_ONES_P2 11'h400
`define ACPC_CONV_PERIOD 64
`define ACPC_FILT_LATENCY 192
`define ACPC_CNT_W 16
`endif

// File: inc/acpc_pkg.sv
// Types for the conversion and power control block
package acpc_pkg;
	typedef enum logic [1:0] {
		ACPC_SYNC = 2'h0,
		ACPC_STARTSTOP = 2'h1,
		ACPC_ONESHOT = 2'h2
	} acpc_mode_e;

	// Gray path: idle, settle, run; power-down beside idle
	typedef enum logic [1:0] {
		ACPC_IDLE = 2'h0,
		ACPC_SETTLE = 2'h1,
		ACPC_RUN = 2'h3,
		ACPC_PDN = 2'h2
	} acpc_state_e;

	typedef struct packed {
		logic [10:0] ones;
		logic wr_pend;
		logic tog;
	} acpc_spi_s;

	typedef struct packed {
		acpc_state_e st;
		logic [15:0] cnt;
		logic [15:0] phase;
		logic [1:0] hold;
		logic run_cmd;
		logic result_ready_n_n;
		logic start_d;
		logic tog_d;
		logic cs_d;
		logic por;
		logic dev_rst;
		logic done;
		logic spi_clr_n;
		logic samp;
		logic filt;
	} acpc_ctl_s;
endpackage

// File: rtl/acpc_sync3.sv
// Three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module acpc_sync3 #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] v;
	} acpc_sync_s;
	acpc_sync_s r;
	acpc_sync_s next_r;

	always_comb begin
		next_r.s1 = d;
		next_r.s2 = r.s1;
		next_r.s3 = r.s2;
		next_r.v = (r.s2 == r.s3) ? r.s3 : r.v;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign q = r.v;
endmodule

// File: rtl/acpc_spi_reset.sv
// Serial-clock side: reset patterns and command-register reset
`timescale 1ns/1ps
`include "acpc_params.svh"
module acpc_spi_reset (
	input wire logic sclk,
	input wire logic spi_rst_n,
	input wire logic sdi,
	input wire logic four_wire,
	input wire logic cmd_last,
	input wire logic [7:0] cmd_byte,
	output logic rst_tog,
	output logic armed
);
	acpc_pkg::acpc_spi_s r;
	acpc_pkg::acpc_spi_s next_r;

	always_comb begin
		next_r = r;
		if (sdi) begin
			if (r.ones != `ACPC_ONES_P2) begin
				next_r.ones = r.ones + 11'h001;
			end
		end else begin
			next_r.ones = 11'h000;
			// Flag stays up until the clock side clears this logic
			if (r.ones >= `ACPC_ONES_P1) begin
				next_r.tog = 1'b1;
			end
		end
		// Four-wire defers the reset to the chip-select rise
		if (cmd_last && cmd_byte == `ACPC_CMD_RESET) begin
			if (four_wire) begin
				next_r.wr_pend = 1'b1;
			end else begin
				next_r.tog = 1'b1;
			end
		end
	end

	always_ff @(negedge sclk or negedge spi_rst_n) begin
		if (!spi_rst_n) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign rst_tog = r.tog;
	assign armed = r.wr_pend | (four_wire & (r.ones == `ACPC_ONES_P2));
endmodule

// File: rtl/acpc_ctl.sv
// Conversion control, power states and device reset of the converter
`timescale 1ns/1ps
`include "acpc_params.svh"
// Overview of operation
// - Idle keeps sampling running; only the filter stops until restart.
// - With standby selected, stopped conversions enter standby and halt sampling.
// - Leaving standby adds 24 clocks before the first result.
// - Power-off bit stops analog, filter and sampling; SPI and registers live.
// - Clearing power-off or any reset leaves power-down.
// - Any reset restarts control, filter and SPI; only serial and command resets pulse the register defaults load.
// - Reset pin low then high resets; power-on also resets.
// - Command byte 58h resets; any other byte does not.
// - Write reset acts at chip-select rise (4-wire) or last falling SCLK.
// - A zero after at least 1023 ones resets at that falling edge.
// - Four-wire: chip-select rise after 1024 ones resets.
// - Writes to registers 04h..0Eh restart the conversion.
// - Two-bit mode; commands only in start/stop and one-shot.
// - After synchronising, first result waits the full filter latency.
// - Synchronized mode converts always and resyncs on start rise.
// - Skip resync when start interval is period multiple within one clock.
// - Start/stop: run on start; ready high at start, low per result.
// - Start/stop: start pulse or second start bit restarts conversion.
// - Stopped: standby ready high after three clocks, else until read.
// - One-shot: each start runs one conversion; stop is ignored.
// - One-shot: ready low at end; standby three clocks, else next start.
// - Every reset sets the power-on flag; writing one clears it.
module acpc_ctl #(
	parameter int CONV_PERIOD = `ACPC_CONV_PERIOD,
	parameter int FILT_LATENCY = `ACPC_FILT_LATENCY
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic start_pin,
	input wire logic [1:0] sync_mode,
	input wire logic standby_select,
	input wire logic power_off_bit,
	input wire logic cmd_wr,
	input wire logic [7:0] cmd_data,
	input wire logic cfg_wr,
	input wire logic [7:0] cfg_addr,
	input wire logic read_eighth_edge,
	input wire logic por_clear,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic sdi,
	input wire logic four_wire,
	input wire logic cmd_last,
	input wire logic [7:0] cmd_byte,
	output logic result_ready_n,
	output logic result_done,
	output logic sampling_on,
	output logic filter_on,
	output logic powered_down,
	output logic por_flag,
	output logic reg_defaults_load
);
	localparam int CW = `ACPC_CNT_W;
	localparam logic [15:0] LAT_LOAD = 16'(FILT_LATENCY - 1);
	localparam logic [15:0] WAKE_LOAD = 16'(FILT_LATENCY - 1 + `ACPC_WAKE_CYC);
	localparam logic [15:0] PER_LOAD = 16'(CONV_PERIOD - 1);

	// The counters are 16 bits wide and the latency must outlast a period
	initial begin
		if (CONV_PERIOD < 4 || CONV_PERIOD + `ACPC_WAKE_CYC >= (1 << CW)) begin
			$error("CONV_PERIOD out of range");
		end
		if (FILT_LATENCY <= CONV_PERIOD
			|| FILT_LATENCY + `ACPC_WAKE_CYC >= (1 << CW)) begin
			$error("FILT_LATENCY out of range");
		end
	end

	localparam acpc_pkg::acpc_ctl_s CTL_RST = '{
		st: acpc_pkg::ACPC_IDLE,
		cnt: 16'h0000,
		phase: 16'h0000,
		hold: 2'h0,
		run_cmd: 1'b0,
		result_ready_n_n: 1'b1,
		start_d: 1'b0,
		tog_d: 1'b0,
		cs_d: 1'b0,
		por: 1'b1,
		dev_rst: 1'b0,
		done: 1'b0,
		spi_clr_n: 1'b0,
		samp: 1'b1,
		filt: 1'b0
	};

	acpc_pkg::acpc_ctl_s r;
	acpc_pkg::acpc_ctl_s next_r;

	logic start_sync;
	logic tog_sync;
	logic cs_sync;
	logic armed_sync;
	logic rst_tog;
	logic armed;

	// Serial-clock logic is cleared from this domain, so it needs no clock
	acpc_spi_reset u_spi (
		.sclk(sclk),
		.spi_rst_n(r.spi_clr_n),
		.sdi(sdi),
		.four_wire(four_wire),
		.cmd_last(cmd_last),
		.cmd_byte(cmd_byte),
		.rst_tog(rst_tog),
		.armed(armed)
	);

	acpc_sync3 #(
		.W(4)
	) u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.d({start_pin, rst_tog, cs_n, armed}),
		.q({start_sync, tog_sync, cs_sync, armed_sync})
	);

	acpc_pkg::acpc_mode_e mode;
	logic start_rise;
	logic soft_rst;
	logic cmd_ok;
	logic cmd_start;
	logic cmd_stop;
	logic cfg_restart;
	logic aligned;
	logic want_run;
	logic restart;
	logic result;
	logic keep_going;

	always_comb begin
		mode = acpc_pkg::acpc_mode_e'(sync_mode);
		start_rise = start_sync & ~r.start_d;
		// Pattern or write reset events, plus the four-wire CS-rise reset
		// Only the rise counts: the clear that follows must not reset again
		soft_rst = (tog_sync & ~r.tog_d)
			| (four_wire & cs_sync & ~r.cs_d & armed_sync);
		cmd_ok = (mode == acpc_pkg::ACPC_STARTSTOP)
			|| (mode == acpc_pkg::ACPC_ONESHOT);
		cmd_start = cmd_wr & cmd_ok & cmd_data[`ACPC_CMD_START_POS];
		cmd_stop = cmd_wr & (mode == acpc_pkg::ACPC_STARTSTOP)
			& cmd_data[`ACPC_CMD_STOP_POS];
		cfg_restart = cfg_wr && cfg_addr >= `ACPC_CFG_FIRST
			&& cfg_addr <= `ACPC_CFG_LAST;
		// A start edge within one clock of the period grid keeps the phase
		aligned = (r.phase == 16'h0000) || (r.phase == 16'h0001)
			|| (r.phase == PER_LOAD);
		unique case (mode)
			acpc_pkg::ACPC_STARTSTOP: want_run = start_sync | r.run_cmd;
			acpc_pkg::ACPC_ONESHOT: want_run = start_rise | cmd_start;
			default: want_run = 1'b1;
		endcase
		unique case (mode)
			acpc_pkg::ACPC_SYNC: restart = start_rise & ~aligned;
			default: restart = start_rise | cmd_start;
		endcase
		restart = restart | cfg_restart;
		result = (r.st == acpc_pkg::ACPC_SETTLE || r.st == acpc_pkg::ACPC_RUN)
			&& r.cnt == 16'h0000;
		unique case (mode)
			acpc_pkg::ACPC_STARTSTOP: keep_going = want_run;
			acpc_pkg::ACPC_ONESHOT: keep_going = 1'b0;
			default: keep_going = 1'b1;
		endcase

		next_r = r;
		next_r.done = 1'b0;
		next_r.dev_rst = 1'b0;
		next_r.start_d = start_sync;
		next_r.tog_d = tog_sync;
		next_r.cs_d = cs_sync;
		// In four-wire mode, hold the serial side cleared while chip select is high and nothing is armed
		next_r.spi_clr_n = ~(four_wire & cs_sync & ~armed_sync);
		if (cmd_start) begin
			next_r.run_cmd = 1'b1;
		end
		if (cmd_stop || mode != acpc_pkg::ACPC_STARTSTOP) begin
			next_r.run_cmd = 1'b0;
		end
		if (por_clear) begin
			next_r.por = 1'b0;
		end
		if (r.phase == PER_LOAD) begin
			next_r.phase = 16'h0000;
		end else begin
			next_r.phase = r.phase + 16'h0001;
		end
		if (read_eighth_edge) begin
			next_r.result_ready_n_n = 1'b1;
		end

		unique case (r.st)
			acpc_pkg::ACPC_PDN: begin
				if (!power_off_bit) begin
					next_r.st = acpc_pkg::ACPC_IDLE;
				end
			end
			acpc_pkg::ACPC_IDLE: begin
				if (r.hold != 2'h0) begin
					next_r.hold = r.hold - 2'h1;
					if (r.hold == 2'h1) begin
						next_r.result_ready_n_n = 1'b1;
					end
				end
				if (want_run) begin
					next_r.st = acpc_pkg::ACPC_SETTLE;
					next_r.cnt = standby_select ? WAKE_LOAD : LAT_LOAD;
					next_r.phase = 16'h0000;
					next_r.result_ready_n_n = 1'b1;
					next_r.hold = 2'h0;
				end
			end
			default: begin
				next_r.cnt = r.cnt - 16'h0001;
				// The next falling edge must be visible even if unread
				if (r.st == acpc_pkg::ACPC_RUN && r.cnt == 16'h0001) begin
					next_r.result_ready_n_n = 1'b1;
				end
				if (result) begin
					next_r.result_ready_n_n = 1'b0;
					next_r.done = 1'b1;
					next_r.cnt = PER_LOAD;
					next_r.st = acpc_pkg::ACPC_RUN;
					if (!keep_going) begin
						// Stop takes effect only once this result is out
						next_r.st = acpc_pkg::ACPC_IDLE;
						if (standby_select) begin
							next_r.hold = `ACPC_RESULT_READY_N_HOLD;
						end
					end
				end
				if (restart) begin
					next_r.st = acpc_pkg::ACPC_SETTLE;
					next_r.cnt = LAT_LOAD;
					next_r.phase = 16'h0000;
					next_r.result_ready_n_n = 1'b1;
					next_r.hold = 2'h0;
				end
			end
		endcase

		if (power_off_bit) begin
			next_r.st = acpc_pkg::ACPC_PDN;
			next_r.result_ready_n_n = 1'b1;
			next_r.hold = 2'h0;
		end

		if (soft_rst) begin
			// Reset wins over everything, power-down included
			next_r = CTL_RST;
			next_r.dev_rst = 1'b1;
			next_r.start_d = start_sync;
			next_r.tog_d = tog_sync;
			next_r.cs_d = cs_sync;
			next_r.por = 1'b1;
		end

		next_r.samp = next_r.st != acpc_pkg::ACPC_PDN
			&& !(next_r.st == acpc_pkg::ACPC_IDLE && standby_select);
		next_r.filt = next_r.st == acpc_pkg::ACPC_SETTLE
			|| next_r.st == acpc_pkg::ACPC_RUN;
	end

	// Power-on and the reset pin both land here
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= CTL_RST;
		end else begin
			r <= next_r;
		end
	end

	assign result_ready_n = r.result_ready_n_n;
	assign result_done = r.done;
	assign sampling_on = r.samp;
	assign filter_on = r.filt;
	assign powered_down = r.st == acpc_pkg::ACPC_PDN;
	assign por_flag = r.por;
	assign reg_defaults_load = r.dev_rst;
endmodule

// File: test/acpc_host_model.sv
// Host model: serial clock, chip select, data input and command strobe
`timescale 1ns/1ps
module acpc_host_model (
	output logic sclk,
	output logic cs_n,
	output logic sdi,
	output logic cmd_last,
	output logic [7:0] cmd_byte
);
	// Serial clock idles low and only runs inside frames
	initial begin
		sclk = 1'b0;
		cs_n = 1'b0;
		sdi = 1'b0;
		cmd_last = 1'b0;
		cmd_byte = 8'h00;
	end
	// Data changes on the rising edge, the device takes it on the falling
	task automatic sh(input int n, input logic b);
		repeat (n) begin
			#24 sclk = 1'b1;
			sdi = b;
			#24 sclk = 1'b0;
		end
		// Released line must not keep showing the last bit
		#24 sdi = ~sdi;
	endtask
	task automatic cw(input logic [7:0] v);
		logic [15:0] f;
		f = {8'h00, v};
		cmd_byte = v;
		for (int i = 15; i >= 0; i--) begin
			#24 sclk = 1'b1;
			sdi = f[i];
			cmd_last = (i == 0);
			#24 sclk = 1'b0;
		end
		#24 cmd_last = 1'b0;
		sdi = ~sdi;
	endtask
	task automatic csel(input logic v);
		#24 cs_n = v;
	endtask
endmodule

// File: test/acpc_ctl_checker.sv
// Port assertions for the conversion and power control block
`timescale 1ns/1ps
module acpc_ctl_checker #(
	parameter int CONV_PERIOD = 64,
	parameter int FILT_LATENCY = 192
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [1:0] sync_mode,
	input wire logic standby_select,
	input wire logic power_off_bit,
	input wire logic por_clear,
	input wire logic result_ready_n,
	input wire logic result_done,
	input wire logic sampling_on,
	input wire logic filter_on,
	input wire logic powered_down,
	input wire logic por_flag,
	input wire logic reg_defaults_load
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	// Cycles since the last result or conversion start
	logic [15:0] g;
	logic first;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			g <= 16'h0000;
			first <= 1'b0;
		end else begin
			g <= (result_done || $rose(filter_on)) ? 16'h0000 : g + 16'h0001;
			first <= $rose(filter_on) ? 1'b1 : (result_done ? 1'b0 : first);
		end
	end
	sequence s_low3;
		##1 !result_ready_n [*2] ##1 result_ready_n;
	endsequence
	a_pdn_ready_high: assert property (powered_down |-> result_ready_n)
		else $error("ready low in power-down");
	a_pdn_all_off: assert property (powered_down |-> !sampling_on && !filter_on)
		else $error("activity in power-down");
	a_pdn_exit: assert property ($fell(power_off_bit) |-> ##[1:3] !powered_down)
		else $error("power-down not left");
	a_idle_sampling: assert property ($past(!standby_select) && !standby_select && !powered_down |-> sampling_on)
		else $error("idle sampling stopped");
	a_done_ready_low: assert property (result_done |-> !result_ready_n)
		else $error("result without ready low");
	a_start_ready_high: assert property ($rose(filter_on) |-> result_ready_n)
		else $error("start without ready high");
	a_standby_three: assert property ($fell(result_ready_n) && standby_select && sync_mode == 2'h2 |-> s_low3)
		else $error("standby ready not three cycles");
	a_result_gap: assert property (result_done |-> g >= CONV_PERIOD - 1)
		else $error("results too close");
	a_first_latency: assert property (result_done && first |-> g >= FILT_LATENCY - 1)
		else $error("first result too early");
	a_por_set: assert property (reg_defaults_load |-> por_flag)
		else $error("reset without power-on flag");
	a_por_clear: assert property (por_clear |=> !por_flag || reg_defaults_load)
		else $error("power-on flag not cleared");
	a_load_pulse: assert property (reg_defaults_load |=> !reg_defaults_load)
		else $error("defaults load longer than one cycle");
endmodule
bind acpc_ctl acpc_ctl_checker #(.CONV_PERIOD(CONV_PERIOD), .FILT_LATENCY(FILT_LATENCY)) acpc_ctl_checker_inst (.*);

// File: test/testbench.sv
// Self-checking bench for the conversion and power control block
`timescale 1ns/1ps
module testbench;
	localparam int CP = 64;
	localparam int FL = 192;
	logic clk = 0, rst_n = 0, start_pin = 0, standby_select = 0;
	logic power_off_bit = 0, cmd_wr = 0, cfg_wr = 0, four_wire = 0;
	logic read_eighth_edge = 0, por_clear = 0;
	logic [1:0] sync_mode = 2'h2;
	logic [7:0] cmd_data = 8'h00, cfg_addr = 8'h00, cmd_byte;
	logic sclk, cs_n, sdi, cmd_last, result_ready_n, result_done;
	logic sampling_on, filter_on, powered_down, por_flag, reg_defaults_load;
	int err_count = 0, samples_checked = 0, n, k;
	acpc_ctl #(.CONV_PERIOD(CP), .FILT_LATENCY(FL)) acpc_ctl_inst (
		.clk(clk),
		.rst_n(rst_n),
		.start_pin(start_pin),
		.sync_mode(sync_mode),
		.standby_select(standby_select),
		.power_off_bit(power_off_bit),
		.cmd_wr(cmd_wr),
		.cmd_data(cmd_data),
		.cfg_wr(cfg_wr),
		.cfg_addr(cfg_addr),
		.read_eighth_edge(read_eighth_edge),
		.por_clear(por_clear),
		.sclk(sclk),
		.cs_n(cs_n),
		.sdi(sdi),
		.four_wire(four_wire),
		.cmd_last(cmd_last),
		.cmd_byte(cmd_byte),
		.result_ready_n(result_ready_n),
		.result_done(result_done),
		.sampling_on(sampling_on),
		.filter_on(filter_on),
		.powered_down(powered_down),
		.por_flag(por_flag),
		.reg_defaults_load(reg_defaults_load)
	);
	acpc_host_model acpc_host_model_inst (
		.sclk(sclk),
		.cs_n(cs_n),
		.sdi(sdi),
		.cmd_last(cmd_last),
		.cmd_byte(cmd_byte)
	);
	always #25 clk = ~clk;
	task automatic chk(input string s, input logic [15:0] v, e);
		samples_checked++;
		if (v !== e) begin
			err_count++;
			$display("unexpected %s: expected %0h seen %0h", s, e, v);
		end
	endtask
	task automatic tk(input int c);
		repeat (c) @(posedge clk);
		#2;
	endtask
	task automatic cmd(input logic [7:0] d);
		cmd_data = d;
		cmd_wr = 1;
		tk(1);
		cmd_wr = 0;
		tk(1);
	endtask
	task automatic cfg(input logic [7:0] a);
		cfg_addr = a;
		cfg_wr = 1;
		tk(1);
		cfg_wr = 0;
		tk(1);
	endtask
	// Edges until the next result, bounded
	task automatic wd(output int c);
		c = 0;
		do begin
			tk(1);
			c++;
		end while (result_done !== 1'b1 && c < 3000);
	endtask
	task automatic cnt(input int c, output int r);
		r = 0;
		repeat (c) begin
			tk(1);
			if (result_done === 1'b1) r++;
		end
	endtask
	task automatic ld(input logic e);
		k = 0;
		repeat (12) begin
			tk(1);
			if (reg_defaults_load === 1'b1) k = 1;
		end
		chk("load", k[0], e);
	endtask
	task automatic print_verdict;
		$display("checked %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		#2000000;
		err_count++;
		print_verdict();
	end
	initial begin
		tk(16);
		rst_n = 1;
		chk("por", por_flag, 1);
		chk("ready", result_ready_n, 1);
		chk("pdn", powered_down, 0);
		por_clear = 1;
		tk(1);
		por_clear = 0;
		tk(1);
		chk("por", por_flag, 0);
		$display("test reset done");
		standby_select = 1;
		tk(4);
		cmd(8'h00);
		cmd(8'h02);
		wd(n);
		chk("latency", n + 1, FL + 24);
		chk("ready", result_ready_n, 0);
		tk(3);
		chk("ready", result_ready_n, 1);
		cmd(8'h00);
		cmd(8'h02);
		tk(20);
		cmd(8'h01);
		wd(n);
		chk("latency", n + 23, FL + 24);
		cnt(FL, k);
		chk("extra", k, 0);
		$display("test one-shot done");
		standby_select = 0;
		sync_mode = 2'h1;
		start_pin = 1;
		wd(n);
		chk("first", n < 3000, 1);
		wd(n);
		chk("period", n, CP);
		tk(9);
		cfg(8'h0F);
		wd(n);
		chk("period", n + 11, CP);
		tk(9);
		cfg(8'h04);
		wd(n);
		chk("restart", n + 1, FL);
		start_pin = 0;
		wd(n);
		chk("finish", n, CP);
		tk(10);
		chk("ready", result_ready_n, 0);
		read_eighth_edge = 1;
		tk(1);
		read_eighth_edge = 0;
		chk("ready", result_ready_n, 1);
		cnt(2 * CP, k);
		chk("stopped", k, 0);
		$display("test start-stop done");
		sync_mode = 2'h0;
		wd(n);
		chk("free run", n < 3000, 1);
		cmd(8'h01);
		wd(n);
		chk("period", n, CP - 2);
		tk(10);
		start_pin = 1;
		wd(n);
		chk("resync", n + 10 > CP, 1);
		$display("test synchronized done");
		power_off_bit = 1;
		tk(3);
		chk("pdn", powered_down, 1);
		chk("sampling", sampling_on, 0);
		chk("filter", filter_on, 0);
		power_off_bit = 0;
		tk(3);
		chk("pdn", powered_down, 0);
		$display("test power-down done");
		start_pin = 0;
		acpc_host_model_inst.sh(1022, 1);
		acpc_host_model_inst.sh(1, 0);
		ld(0);
		acpc_host_model_inst.sh(1023, 1);
		acpc_host_model_inst.sh(1, 0);
		ld(1);
		chk("por", por_flag, 1);
		acpc_host_model_inst.cw(8'h57);
		ld(0);
		acpc_host_model_inst.cw(8'h58);
		ld(1);
		four_wire = 1;
		acpc_host_model_inst.csel(1);
		tk(2);
		acpc_host_model_inst.csel(0);
		tk(8);
		acpc_host_model_inst.sh(1024, 1);
		acpc_host_model_inst.csel(1);
		ld(1);
		acpc_host_model_inst.csel(0);
		tk(8);
		acpc_host_model_inst.cw(8'h58);
		ld(0);
		acpc_host_model_inst.csel(1);
		ld(1);
		$display("test serial reset done");
		print_verdict();
	end
endmodule
